// File: rtl/pscs_pkg.sv
/*
 * Shared constants and types of the power-save clock scaler.
 * Assumes a single system clock domain; no registers reached by software.
 */
package pscs_pkg;

  // Field positions inside the oscillator control word.
  localparam int OSC_SLEEP_SEL_BIT = 4;
  localparam int OSC_DIV_LSB       = 19;
  localparam int OSC_DIV_MSB       = 20;
  localparam int OSC_WIDTH         = 32;

  // Divider encodings: ratio 1:1, 1:2, 1:4, 1:8.
  localparam logic [1:0] DIV_BY_1 = 2'h0;
  localparam logic [1:0] DIV_BY_2 = 2'h1;
  localparam logic [1:0] DIV_BY_4 = 2'h2;
  localparam logic [1:0] DIV_BY_8 = 2'h3;

  // Divider counter width, enough for the 1:8 ratio.
  localparam int DIV_CNT_W = 3;
  localparam logic [DIV_CNT_W-1:0] DIV_CNT_ZERO = 3'h0;
  localparam logic [DIV_CNT_W-1:0] DIV_CNT_ONE  = 3'h1;

  // Width of interrupt and CPU priority levels.
  localparam int PRIO_W = 3;

  // Power modes.
  typedef enum logic [1:0] {
    PSCS_RUN,
    PSCS_IDLE,
    PSCS_SLEEP
  } pscs_mode_t;

endpackage : pscs_pkg

// File: rtl/pscs_pb_divider.sv
/*
 * Peripheral bus clock divider: produces a one-cycle tick on every
 * peripheral bus clock edge, at a ratio of 1, 2, 4 or 8 system clocks.
 * Assumes it runs on the system clock and the ratio input is synchronous.
 */
`timescale 1ns/1ns
`default_nettype none

module pscs_pb_divider
  import pscs_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 rst_b,
  input  wire logic [1:0]           div_sel,
  input  wire logic                 run,
  output logic                      pb_tick,
  output logic [DIV_CNT_W-1:0]      pb_phase
);

  logic [DIV_CNT_W-1:0] cnt_reg;
  logic [DIV_CNT_W-1:0] cnt_next;
  logic [DIV_CNT_W-1:0] limit;
  logic                 tick_reg;
  logic                 tick_next;

  // Terminal count for the selected ratio; a change takes effect at once.
  always_comb begin
    case (div_sel)
      DIV_BY_1: limit = 3'h0;
      DIV_BY_2: limit = 3'h1;
      DIV_BY_4: limit = 3'h3;
      DIV_BY_8: limit = 3'h7;
      default:  limit = 3'h0;
    endcase
  end

  // Count while running; a stopped divider holds the bus clock still.
  always_comb begin
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    if (run) begin
      if (cnt_reg >= limit) begin
        cnt_next  = DIV_CNT_ZERO;
        tick_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + DIV_CNT_ONE;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg  <= DIV_CNT_ZERO;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign pb_tick  = tick_reg;
  assign pb_phase = cnt_reg;

endmodule : pscs_pb_divider

`default_nettype wire

// File: rtl/pscs_read_stall.sv
/*
 * Holds a CPU peripheral read until the next peripheral bus clock tick.
 * Assumes the CPU keeps the request high until it sees the done pulse.
 */
`timescale 1ns/1ns
`default_nettype none

module pscs_read_stall (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic rd_req,
  input  wire logic pb_tick,
  output logic      rd_stall,
  output logic      rd_done
);

  logic pend_reg;
  logic pend_next;
  logic done_reg;
  logic done_next;

  // A read completes on the first tick after it is raised.
  always_comb begin
    pend_next = pend_reg;
    done_next = 1'b0;
    if (pend_reg && pb_tick) begin
      pend_next = 1'b0;
      done_next = 1'b1;
    end else if (rd_req && !pend_reg && !done_reg) begin
      pend_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      pend_reg <= pend_next;
      done_reg <= done_next;
    end
  end

  // Stall is combinational so the CPU holds in the request cycle itself.
  assign rd_stall = (rd_req && !done_reg) || pend_reg;
  assign rd_done  = done_reg;

endmodule : pscs_read_stall

`default_nettype wire

// File: rtl/pscs_top.sv
/*
 * Power-save mode controller and peripheral bus clock scaler: it moves the
 * core between run, idle and sleep, gates the clocks that follow from the
 * mode, divides the bus clock and holds peripheral reads for a bus edge.
 * Assumes the CPU, interrupt controller and peripherals share sys_clk and
 * present their strobes and levels on it; the watchdog timeout is an
 * asynchronous level and is synchronised here. The oscillator control word
 * is a settled level from a register on sys_clk.
 */
`timescale 1ns/1ns
`default_nettype none

module pscs_top
  import pscs_pkg::*;
#(
  parameter int NUM_PERIPH = 8
)(
  input  wire logic                    sys_clk,
  input  wire logic                    rst_b,
  input  wire logic [OSC_WIDTH-1:0]    oscillator_control_reg,
  input  wire logic                    wait_exec,
  input  wire logic                    irq_valid,
  input  wire logic [PRIO_W-1:0]       irq_prio,
  input  wire logic                    irq_sleep_capable,
  input  wire logic [PRIO_W-1:0]       cpu_prio,
  input  wire logic                    watchdog_timeout_source,
  input  wire logic [NUM_PERIPH-1:0]   stop_in_idle_bit,
  input  wire logic                    cpu_rd_req,
  input  wire logic                    src_was_disabled,
  output logic                         cpu_halt,
  output logic                         cpu_wake,
  output logic                         system_core_clock_en,
  output logic                         peripheral_bus_clock,
  output logic                         pb_tick,
  output logic [NUM_PERIPH-1:0]        periph_run,
  output logic                         cpu_rd_stall,
  output logic                         cpu_rd_done,
  output logic                         startup_delay_req,
  output logic [1:0]                   power_mode
);

  // Refuse sizes and field layouts that the slicing below cannot serve.
  // The divider field is sliced as two bits, so it must stay two bits.
  generate
    if (NUM_PERIPH < 1) begin : g_bad_n
      $error("NUM_PERIPH must be at least one");
    end
    if (OSC_DIV_MSB != OSC_DIV_LSB + 1) begin : g_bad_div
      $error("Divider field must be two bits wide");
    end
    if (OSC_DIV_MSB >= OSC_WIDTH) begin : g_bad_msb
      $error("Divider field lies outside the control word");
    end
    if (OSC_SLEEP_SEL_BIT >= OSC_WIDTH) begin : g_bad_sel
      $error("Sleep select bit lies outside the control word");
    end
    if (DIV_CNT_W < 3) begin : g_bad_cnt
      $error("Divider counter too narrow for the slowest ratio");
    end
    if (PRIO_W < 1) begin : g_bad_prio
      $error("Priority levels need at least one bit");
    end
  endgenerate

  pscs_mode_t mode_reg;
  pscs_mode_t mode_next;
  logic       wake_reg;
  logic       wake_next;
  logic       wdt_meta_reg;
  logic       wdt_sync_reg;
  logic       startup_reg;
  logic       startup_next;
  logic       sleep_sel;
  logic [1:0] periph_bus_divider;
  logic       irq_high;
  logic       pb_run;
  logic       pb_clk_reg;
  logic       pb_clk_next;
  logic [DIV_CNT_W-1:0] pb_phase;
  logic                  halt_reg;
  logic                  halt_next;
  logic                  clk_en_reg;
  logic                  clk_en_next;
  logic [NUM_PERIPH-1:0] prun_reg;
  logic [NUM_PERIPH-1:0] prun_next;

  // Decide whether an interrupt outranks the current CPU level.
  function automatic logic prio_above(input logic [PRIO_W-1:0] a,
                                      input logic [PRIO_W-1:0] b);
    prio_above = (a > b);
  endfunction : prio_above

  // The CPU is held in every mode but run.
  function automatic logic mode_halts_cpu(input pscs_mode_t m);
    mode_halts_cpu = (m != PSCS_RUN);
  endfunction : mode_halts_cpu

  // Clocks keep running in every mode but sleep.
  function automatic logic mode_keeps_clock(input pscs_mode_t m);
    mode_keeps_clock = (m != PSCS_SLEEP);
  endfunction : mode_keeps_clock

  assign sleep_sel          = oscillator_control_reg[OSC_SLEEP_SEL_BIT];
  assign periph_bus_divider =
    oscillator_control_reg[OSC_DIV_MSB:OSC_DIV_LSB];
  assign irq_high           = irq_valid && prio_above(irq_prio, cpu_prio);

  // Watchdog timeout crosses in from its own oscillator. Only the second
  // flop is read, so a metastable first stage never reaches the mode
  // logic; the price is two cycles of extra exit latency.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wdt_meta_reg <= 1'b0;
      wdt_sync_reg <= 1'b0;
    end else begin
      wdt_meta_reg <= watchdog_timeout_source;
      wdt_sync_reg <= wdt_meta_reg;
    end
  end

  // Mode transitions; reset itself forces run through the flop reset.
  // The watchdog is tested before any interrupt so that a timeout always
  // ends a low-power mode, whatever the interrupt priorities are. A wait
  // strobe is only meaningful in run, where the CPU can execute it.
  always_comb begin
    mode_next    = mode_reg;
    wake_next    = 1'b0;
    startup_next = 1'b0;
    case (mode_reg)
      PSCS_RUN: begin
        if (wait_exec) begin
          if (sleep_sel) begin
            mode_next = PSCS_SLEEP;
          end else begin
            mode_next = PSCS_IDLE;
          end
        end
      end
      PSCS_IDLE: begin
        // A wait strobe is ignored here: the CPU is already halted.
        // Watchdog exit from idle.
        if (wdt_sync_reg) begin
          mode_next = PSCS_RUN;
          wake_next = 1'b1;
        end else if (irq_high) begin
          mode_next = PSCS_RUN;
          wake_next = 1'b1;
        end
        startup_next = 1'b0;
      end
      PSCS_SLEEP: begin
        // Only sleep-capable sources can reach the controller in sleep.
        // Watchdog exit from sleep.
        if (wdt_sync_reg) begin
          mode_next    = PSCS_RUN;
          wake_next    = 1'b1;
          startup_next = src_was_disabled;
        end else if (irq_valid && irq_sleep_capable && irq_high) begin
          mode_next    = PSCS_RUN;
          wake_next    = 1'b1;
          // Delay only for a stopped source.
          startup_next = src_was_disabled;
        end else if (irq_valid && irq_sleep_capable) begin
          mode_next = PSCS_IDLE;
        end
      end
      default: begin
        mode_next = PSCS_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg    <= PSCS_RUN;
      wake_reg    <= 1'b0;
      startup_reg <= 1'b0;
    end else begin
      mode_reg    <= mode_next;
      wake_reg    <= wake_next;
      startup_reg <= startup_next;
    end
  end

  // Bus clock stops only in sleep.
  assign pb_run = mode_keeps_clock(mode_reg);

  pscs_pb_divider u_div (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .div_sel  (periph_bus_divider),
    .run      (pb_run),
    .pb_tick  (pb_tick),
    .pb_phase (pb_phase)
  );

  // Bus clock level rises the cycle after each tick and falls one cycle later; at 1:1 it follows pb_run.
  // A registered level cannot toggle at the system rate, so at 1:1 the
  // level only shows that the bus runs; peripherals time themselves from
  // pb_tick, which is the real bus clock enable.
  always_comb begin
    pb_clk_next = pb_clk_reg;
    if (periph_bus_divider == DIV_BY_1) begin
      pb_clk_next = pb_run;
    end else if (pb_phase == DIV_CNT_ZERO) begin
      pb_clk_next = 1'b1;
    end else if (pb_phase == DIV_CNT_ONE) begin
      pb_clk_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pb_clk_reg <= 1'b0;
    end else begin
      pb_clk_reg <= pb_clk_next;
    end
  end

  // Reads wait for the next bus tick.
  // The stall is combinational so the core stops in the request cycle;
  // the added latency grows with the divider ratio.
  pscs_read_stall u_rd (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .rd_req   (cpu_rd_req),
    .pb_tick  (pb_tick),
    .rd_stall (cpu_rd_stall),
    .rd_done  (cpu_rd_done)
  );

  // Mode-derived outputs come from flip-flops fed by the next mode, so
  // they change on the same edge as power_mode and cannot glitch while
  // the mode decode settles. Reset values match the run mode.
  // Halt in low power.
  always_comb begin
    halt_next   = mode_halts_cpu(mode_next);
    clk_en_next = mode_keeps_clock(mode_next);
  end

  // Per-peripheral stop in idle.
  // A stop-in-idle bit changed while idle takes effect one cycle later.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PERIPH; gi++) begin : g_periph
      assign prun_next[gi] = mode_keeps_clock(mode_next) &&
        !((mode_next == PSCS_IDLE) && stop_in_idle_bit[gi]);
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      halt_reg   <= 1'b0;
      clk_en_reg <= 1'b1;
      prun_reg   <= {NUM_PERIPH{1'b1}};
    end else begin
      halt_reg   <= halt_next;
      clk_en_reg <= clk_en_next;
      prun_reg   <= prun_next;
    end
  end

  assign cpu_halt             = halt_reg;
  assign system_core_clock_en = clk_en_reg;
  assign periph_run           = prun_reg;

  // Wake and start-up requests are one-cycle pulses; a core that needs
  // them longer must latch them itself.
  assign cpu_wake             = wake_reg;
  assign startup_delay_req    = startup_reg;
  assign peripheral_bus_clock = pb_clk_reg;
  assign power_mode           = mode_reg;

endmodule : pscs_top

`default_nettype wire

// File: testbench/pscs_top_checker.sv
/* Port assertions of the power-save clock scaler.
   Assumes a bind into pscs_top and its single clock domain. */
`timescale 1ns/1ns
`default_nettype none
module pscs_top_checker
  import pscs_pkg::*;
(
  input wire logic                 sys_clk,
  input wire logic                 rst_b,
  input wire logic [OSC_WIDTH-1:0] oscillator_control_reg,
  input wire logic                 wait_exec,
  input wire logic                 irq_valid,
  input wire logic [PRIO_W-1:0]    irq_prio,
  input wire logic                 irq_sleep_capable,
  input wire logic [PRIO_W-1:0]    cpu_prio,
  input wire logic                 watchdog_timeout_source,
  input wire logic                 cpu_halt,
  input wire logic                 cpu_wake,
  input wire logic                 system_core_clock_en,
  input wire logic                 pb_tick,
  input wire logic                 cpu_rd_done,
  input wire logic                 startup_delay_req,
  input wire logic [1:0]           power_mode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // The watchdog is synchronised, so only a quiet spell rules it out.
  sequence s_wd_quiet;
    (!watchdog_timeout_source) [*4];
  endsequence
  sequence s_irq_hi;
    irq_valid && irq_prio > cpu_prio;
  endsequence
  a_wait_idle: assert property (
    power_mode == 2'h0 && wait_exec && !oscillator_control_reg[4]
    |=> power_mode == 2'h1 && cpu_halt) else $error("wait not idle");
  a_wait_sleep: assert property (
    power_mode == 2'h0 && wait_exec && oscillator_control_reg[4]
    |=> power_mode == 2'h2 && !system_core_clock_en) else $error("no sleep");
  a_idle_clock: assert property (
    power_mode == 2'h1 |-> cpu_halt && system_core_clock_en)
    else $error("idle clock wrong");
  a_sleep_wake: assert property (
    (power_mode == 2'h2 && irq_sleep_capable) ##0 s_irq_hi
    |=> power_mode == 2'h0 && cpu_wake) else $error("sleep no wake");
  a_sleep_low: assert property (
    s_wd_quiet ##0 (power_mode == 2'h2 && irq_valid && irq_sleep_capable
    && irq_prio <= cpu_prio) |=> power_mode == 2'h1 && cpu_halt)
    else $error("sleep not to idle");
  a_idle_hold: assert property (
    s_wd_quiet ##0 (power_mode == 2'h1 && !(irq_valid && irq_prio > cpu_prio))
    |=> power_mode == 2'h1) else $error("idle left");
  a_wdt_exit: assert property (
    $rose(watchdog_timeout_source) && power_mode != 2'h0
    |-> ##[1:4] power_mode == 2'h0) else $error("watchdog no exit");
  a_done_tick: assert property (
    cpu_rd_done |-> $past(pb_tick)) else $error("done without tick");
  a_idle_nodelay: assert property (
    cpu_wake && $past(power_mode) == 2'h1 |-> !startup_delay_req)
    else $error("idle exit delayed");
endmodule : pscs_top_checker
bind pscs_top pscs_top_checker u_chk (
  .sys_clk(sys_clk), .rst_b(rst_b),
  .oscillator_control_reg(oscillator_control_reg),
  .wait_exec(wait_exec), .irq_valid(irq_valid), .irq_prio(irq_prio),
  .irq_sleep_capable(irq_sleep_capable), .cpu_prio(cpu_prio),
  .watchdog_timeout_source(watchdog_timeout_source),
  .cpu_halt(cpu_halt), .cpu_wake(cpu_wake),
  .system_core_clock_en(system_core_clock_en), .pb_tick(pb_tick),
  .cpu_rd_done(cpu_rd_done), .startup_delay_req(startup_delay_req),
  .power_mode(power_mode));
`default_nettype wire

// File: testbench/pscs_cpu_model.sv
/* Behavioural CPU read master facing the read stall port.
   Assumes start pulses for one cycle only while no read is open. */
`timescale 1ns/1ns
`default_nettype none
module pscs_cpu_model (
  input  wire logic      sys_clk,
  input  wire logic      rst_b,
  input  wire logic      start,
  input  wire logic      cpu_rd_done,
  output var  logic      cpu_rd_req,
  output var  logic [3:0] lat
);
  // hold until done
  // A real core stalls, so the request stays up until done is sampled.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_rd_req <= 1'b0;
      lat <= 4'h0;
    end else if (cpu_rd_req && cpu_rd_done) begin
      cpu_rd_req <= 1'b0;
    end else if (cpu_rd_req) begin
      lat <= lat + 4'h1;
    end else if (start) begin
      cpu_rd_req <= 1'b1;
      lat <= 4'h0;
    end
  end
endmodule : pscs_cpu_model
`default_nettype wire

// File: testbench/tb_power_save_clock_scaler.sv
/* Self-checking bench of the power-save clock scaler.
   Assumes the CPU read model and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
module tb_power_save_clock_scaler;
  import pscs_pkg::*;
  logic        clk, rst_b, wx, iv, isc, wd_to, srcd, start;
  logic        halt, wake, sce, tick, stall, done, sdr, req, pbc;
  logic [31:0] osc;
  logic [2:0]  ip, cp;
  logic [7:0]  sib, prun;
  logic [1:0]  mode;
  logic [3:0]  lat;
  int          num_errors, checks_done, cycles;
  pscs_top #(.NUM_PERIPH(8)) uut (
    .sys_clk(clk), .rst_b(rst_b), .oscillator_control_reg(osc),
    .wait_exec(wx), .irq_valid(iv), .irq_prio(ip),
    .irq_sleep_capable(isc), .cpu_prio(cp),
    .watchdog_timeout_source(wd_to), .stop_in_idle_bit(sib),
    .cpu_rd_req(req), .src_was_disabled(srcd), .cpu_halt(halt),
    .cpu_wake(wake), .system_core_clock_en(sce),
    .peripheral_bus_clock(pbc), .pb_tick(tick), .periph_run(prun),
    .cpu_rd_stall(stall), .cpu_rd_done(done),
    .startup_delay_req(sdr), .power_mode(mode));
  pscs_cpu_model cpu (.sys_clk(clk), .rst_b(rst_b), .start(start),
    .cpu_rd_done(done), .cpu_rd_req(req), .lat(lat));
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic to_tick(output int k);
    k = 0;
    do begin
      cyc(1);
      k++;
    end while (tick !== 1'b1 && k < 20);
  endtask : to_tick
  task automatic do_wait(logic sel, logic [1:0] m);
    osc[4] = sel;
    wx = 1'b1;
    cyc(1);
    wx = 1'b0;
    chk("mode_halt", {5'h0, 1'b1, m}, 8'({halt, mode}));
  endtask : do_wait
  task automatic irq(logic [2:0] p, logic s);
    ip = p;
    isc = s;
    iv = 1'b1;
    cyc(1);
    iv = 1'b0;
  endtask : irq
  task automatic end_of_test();
    if (num_errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  // A reset taken from idle must land in run.
  task automatic t_reset();
    do_wait(1'b0, 2'h1);
    rst_b = 1'b0;
    cyc(1);
    chk("reset_mode", 8'h0, 8'({halt, wake, mode}));
    rst_b = 1'b1;
    cyc(2);
  endtask : t_reset
  // Each ratio is timed, then a read is stalled to the next tick.
  task automatic t_div();
    int k;
    for (int d = 0; d < 4; d++) begin
      osc[20:19] = d[1:0];
      cyc(10);
      to_tick(k);
      to_tick(k);
      chk("pb_period", 8'(1 << d), 8'(k));
      chk("pb_clk_tick", 8'(d == 0), 8'(pbc));
      cyc(1);
      chk("pb_clk_next", 8'h1, 8'(pbc));
      chk("sys_clk_en", 8'h1, 8'(sce));
      start = 1'b1;
      cyc(1);
      start = 1'b0;
      chk("rd_stall", 8'h1, 8'(stall));
      k = 0;
      while (req && k < 20) begin
        cyc(1);
        k++;
      end
      chk("rd_lat", 8'h1, 8'(lat > 0 && lat <= (1 << d) + 1));
    end
  endtask : t_div
  task automatic t_idle();
    srcd = 1'b1;
    do_wait(1'b0, 2'h1);
    chk("idle_clk", 8'h1, 8'(sce));
    chk("idle_run", ~sib, prun);
    irq(3'h3, 1'b1);
    chk("idle_hold", 8'h1, 8'(mode));
    irq(3'h4, 1'b0);
    chk("idle_wake", 8'h4, 8'({wake, mode}));
    chk("no_startup", 8'h0, 8'(sdr));
    chk("run_periph", 8'hff, prun);
  endtask : t_idle
  // Sleep drops to idle on a low request, then the watchdog ends it.
  task automatic t_sleep();
    int k;
    do_wait(1'b1, 2'h2);
    cyc(2);
    chk("sleep_clk", 8'h0, 8'({sce, tick}));
    irq(3'h2, 1'b1);
    chk("sleep_low", 8'h1, 8'(mode));
    to_tick(k);
    chk("pb_restart", 8'h1, 8'(tick));
    wd_to = 1'b1;
    cyc(4);
    wd_to = 1'b0;
    chk("wd_exit", 8'h0, 8'(mode));
    // Let the synchroniser drain so the old timeout cannot end the next mode.
    cyc(3);
  endtask : t_sleep
  task automatic t_wake();
    do_wait(1'b1, 2'h2);
    irq(3'h7, 1'b0);
    chk("sleep_keep", 8'h2, 8'(mode));
    irq(3'h5, 1'b1);
    chk("sleep_wake", 8'h4, 8'({wake, mode}));
    chk("startup", 8'h1, 8'(sdr));
  endtask : t_wake
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // The ceiling sits far above the hundred-odd cycles the tests need.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    rst_b = 1'b0;
    {wx, iv, isc, wd_to, srcd, start} = 6'h0;
    osc = 32'h0;
    ip = 3'h0;
    cp = 3'h3;
    sib = 8'h5a;
    cyc(12);
    rst_b = 1'b1;
    cyc(1);
    t_reset();
    t_div();
    t_idle();
    t_sleep();
    t_wake();
    end_of_test();
  end
endmodule : tb_power_save_clock_scaler
`default_nettype wire
